// ==== hdl/jpp_pkg.sv ====
package jpp_pkg;
    localparam int IR_W = 4;
    localparam int KEY_W = 16;
    localparam int CMD_W = 15;
    localparam int PAGE_W = 8;
    localparam logic [IR_W-1:0] IR_HOLD_RESET = 4'hC;
    localparam logic [IR_W-1:0] IR_UNLOCK = 4'h4;
    localparam logic [IR_W-1:0] IR_COMMAND = 4'h5;
    localparam logic [IR_W-1:0] IR_PAGE_LOAD = 4'h6;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [KEY_W-1:0] UNLOCK_KEY = 16'hA370;
    localparam logic [KEY_W-1:0] KEY_RESET = 16'h0000;
    localparam logic [1:0] EXT_RST_CLKS = 2'h2;
    localparam int PAGE_LOAD_MAX_TCK = 11;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
        TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jpp_tap_t;
endpackage

// ==== hdl/jpp_sync.sv ====
module jpp_sync
    import jpp_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,   // Destination clock
    input  wire logic             rst,   // Asynchronous reset, high
    input  wire logic [WIDTH-1:0] d,     // Foreign level
    output logic      [WIDTH-1:0] q      // Settled level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } jpp_sync_t;

    jpp_sync_t s_reg;
    jpp_sync_t s_next;

    if (WIDTH < 1)
    begin : bad_width
        $error("jpp_sync width must be at least one");
    end

    // Change accepted only once second and third stage agree
    always_comb
    begin
        s_next = s_reg;
        s_next.s1 = d;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        if (s_reg.s2 == s_reg.s3)
        begin
            s_next.q = s_reg.s3;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.q;
endmodule

// ==== hdl/jpp_port.sv ====
module jpp_port
    import jpp_pkg::*;
(
    input  wire logic              ref_clk,          // System clock, 20 MHz
    input  wire logic              rst,              // Asynchronous reset, high
    input  wire logic              tck,              // Test clock
    input  wire logic              tms,              // Test mode select
    input  wire logic              tdi,              // Test data in
    output logic                   tdo,              // Test data out
    output logic                   tdo_oe_n,         // Low while driving tdo
    input  wire logic              test_port_enable_fuse, // Fuse, high = programmed
    input  wire logic              ext_reset_n,      // External reset pin
    input  wire logic              disable_set,      // Core sets disable bit
    output logic                   test_port_disable_bit, // Disable bit state
    output logic                   core_hold_reset,  // Holds core in reset
    output logic                   prog_mode,        // Programming mode active
    output logic      [CMD_W-1:0]  flash_cmd,        // Applied command
    output logic                   flash_cmd_load,   // Command applied, pulse
    output logic                   flash_exec,       // Execute pulse
    input  wire logic [CMD_W-1:0]  flash_result,     // Result of command
    input  wire logic              flash_result_valid, // Result strobe
    output logic      [PAGE_W-1:0] page_byte,        // Byte for page buffer
    output logic                   page_byte_high,   // Byte is high half
    output logic                   page_byte_write,  // Page buffer write pulse
    output logic                   page_word_inc     // Word counter advance
);
    typedef struct packed {
        jpp_tap_t          st;
        logic [IR_W-1:0]   ir_sh;
        logic [IR_W-1:0]   ir;
        logic              rst_bit;
        logic [KEY_W-1:0]  key;
        logic [CMD_W-1:0]  cmd;
        logic [CMD_W-1:0]  cmd_out;
        logic              byp;
        logic              prog;
        logic              hi;
        logic              first;
        logic              pend;
        logic              cmd_tgl;
        logic              exec_tgl;
        logic              page_tgl;
        logic [PAGE_W-1:0] page_hold;
        logic              page_hi;
        logic              page_inc;
        logic              res_seen;
        logic [CMD_W-1:0]  res;
        logic              tdo;
        logic              tdo_oe_n;
    } jpp_tck_t;

    typedef struct packed {
        logic [CMD_W-1:0]  cmd;
        logic              cmd_load;
        logic              exec;
        logic [PAGE_W-1:0] pbyte;
        logic              phigh;
        logic              pwrite;
        logic              winc;
        logic              wpend;
        logic [2:0]        seen;
        logic              prog;
        logic              dis;
        logic [1:0]        lowcnt;
        logic [CMD_W-1:0]  res;
        logic              res_tgl;
        logic              access;
    } jpp_ref_t;

    localparam jpp_tck_t TCK_INIT = '{st: TAP_RESET, ir: IR_BYPASS, tdo_oe_n: 1'b1,
                                      key: KEY_RESET, default: '0};

    jpp_tck_t t_reg;
    jpp_tck_t t_next;
    jpp_ref_t r_reg;
    jpp_ref_t r_next;
    jpp_tap_t tap_nx;
    logic [1:0] pin_q;
    logic [3:0] ev_q;
    logic [1:0] back_q;
    logic [2:0] ev;

    function automatic jpp_tap_t tap_step(input jpp_tap_t s, input logic m);
        unique case (s)
            TAP_RESET:  tap_step = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:   tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_step = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_step = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

    // Pins into the system domain
    jpp_sync #(.WIDTH(2)) u_pin_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({test_port_enable_fuse, ext_reset_n}),
        .q   (pin_q)
    );

    // Event toggles and mode level, test domain to system domain
    jpp_sync #(.WIDTH(4)) u_ev_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({t_reg.prog, t_reg.page_tgl, t_reg.exec_tgl, t_reg.cmd_tgl}),
        .q   (ev_q)
    );

    // Access level and result toggle, system domain to test domain
    jpp_sync #(.WIDTH(2)) u_back_sync (
        .clk (tck),
        .rst (rst),
        .d   ({r_reg.res_tgl, r_reg.access}),
        .q   (back_q)
    );

    assign tap_nx = tap_step(t_reg.st, tms);

    always_comb
    begin
        t_next = t_reg;
        t_next.st = tap_nx;
        if (back_q[1] != t_reg.res_seen)
        begin
            // Result word is stable long before its toggle arrives
            t_next.res_seen = back_q[1];
            t_next.res = r_reg.res;
        end
        unique case (t_reg.st)
            TAP_RESET:
            begin
                t_next.ir = IR_BYPASS;
                t_next.pend = 1'b0;
            end
            TAP_IDLE:
            begin
                if (t_reg.pend)
                begin
                    t_next.exec_tgl = ~t_reg.exec_tgl;
                    t_next.pend = 1'b0;
                end
            end
            TAP_CAP_IR: t_next.ir_sh = IR_CAPTURE;
            TAP_SH_IR: t_next.ir_sh = {tdi, t_reg.ir_sh[IR_W-1:1]};
            TAP_UPD_IR:
            begin
                t_next.ir = t_reg.ir_sh;
                if (t_reg.ir_sh == IR_PAGE_LOAD)
                begin
                    t_next.hi = 1'b0;
                    t_next.first = 1'b1;
                end
            end
            TAP_CAP_DR:
            begin
                if (t_reg.ir == IR_COMMAND)
                begin
                    t_next.cmd = t_reg.res;
                end
                t_next.byp = 1'b0;
            end
            TAP_SH_DR:
            begin
                case (t_reg.ir)
                    IR_HOLD_RESET: t_next.rst_bit = tdi;
                    IR_UNLOCK: t_next.key = {tdi, t_reg.key[KEY_W-1:1]};
                    IR_COMMAND: t_next.cmd = {tdi, t_reg.cmd[CMD_W-1:1]};
                    IR_PAGE_LOAD: t_next.cmd[PAGE_W-1:0] =
                        {tdi, t_reg.cmd[PAGE_W-1:1]};
                    default: t_next.byp = tdi;
                endcase
            end
            TAP_UPD_DR:
            begin
                case (t_reg.ir)
                    IR_UNLOCK: t_next.prog = (t_reg.key == UNLOCK_KEY);
                    IR_COMMAND:
                    begin
                        if (t_reg.prog)
                        begin
                            t_next.cmd_out = t_reg.cmd;
                            t_next.cmd_tgl = ~t_reg.cmd_tgl;
                            t_next.pend = 1'b1;
                        end
                    end
                    IR_PAGE_LOAD:
                    begin
                        if (t_reg.prog)
                        begin
                            t_next.page_hold = t_reg.cmd[PAGE_W-1:0];
                            t_next.page_hi = t_reg.hi;
                            t_next.page_inc = ~t_reg.hi & ~t_reg.first;
                            t_next.first = t_reg.hi & t_reg.first;
                            t_next.hi = ~t_reg.hi;
                            t_next.page_tgl = ~t_reg.page_tgl;
                        end
                    end
                    default: ;
                endcase
            end
            TAP_SEL_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
            TAP_SEL_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR: ;
        endcase
        // Without fuse and cleared disable bit the port stays inert
        if (!back_q[0])
        begin
            t_next.prog = 1'b0;
            t_next.rst_bit = 1'b0;
        end
        t_next.tdo_oe_n = ~(back_q[0] & (tap_nx == TAP_SH_IR || tap_nx == TAP_SH_DR));
        if (tap_nx == TAP_SH_IR)
        begin
            t_next.tdo = t_next.ir_sh[0];
        end
        else
        begin
            case (t_next.ir)
                IR_HOLD_RESET: t_next.tdo = t_next.rst_bit;
                IR_UNLOCK: t_next.tdo = t_next.key[0];
                IR_COMMAND, IR_PAGE_LOAD: t_next.tdo = t_next.cmd[0];
                default: t_next.tdo = t_next.byp;
            endcase
        end
    end

    // Reset bit never touches the TAP state itself
    always_ff @(posedge tck or posedge rst)
    begin
        if (rst)
        begin
            t_reg <= TCK_INIT;
        end
        else
        begin
            t_reg <= t_next;
        end
    end

    assign ev = ev_q[2:0] ^ r_reg.seen;

    always_comb
    begin
        r_next = r_reg;
        r_next.cmd_load = 1'b0;
        r_next.exec = 1'b0;
        r_next.pwrite = 1'b0;
        r_next.winc = 1'b0;
        r_next.seen = ev_q[2:0];
        r_next.prog = ev_q[3];
        if (ev[0])
        begin
            r_next.cmd = t_reg.cmd_out;
            r_next.cmd_load = 1'b1;
        end
        if (ev[1])
        begin
            r_next.exec = 1'b1;
        end
        if (r_reg.wpend)
        begin
            r_next.pwrite = 1'b1;
            r_next.wpend = 1'b0;
        end
        if (ev[2])
        begin
            r_next.pbyte = t_reg.page_hold;
            r_next.phigh = t_reg.page_hi;
            r_next.winc = t_reg.page_inc;
            r_next.wpend = t_reg.page_inc;
            r_next.pwrite = ~t_reg.page_inc;
        end
        // While the pin is low the clear beats any set from the core
        if (!pin_q[0])
        begin
            if (r_reg.lowcnt == EXT_RST_CLKS - 2'h1)
            begin
                r_next.dis = 1'b0;
            end
            else
            begin
                r_next.lowcnt = r_reg.lowcnt + 2'h1;
            end
        end
        else
        begin
            r_next.lowcnt = 2'h0;
            if (disable_set)
            begin
                r_next.dis = 1'b1;
            end
        end
        r_next.access = pin_q[1] & ~r_reg.dis;
        if (flash_result_valid)
        begin
            r_next.res = flash_result;
            r_next.res_tgl = ~r_reg.res_tgl;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign tdo = t_reg.tdo;
    assign tdo_oe_n = t_reg.tdo_oe_n;
    assign core_hold_reset = t_reg.rst_bit;
    assign test_port_disable_bit = r_reg.dis;
    assign prog_mode = r_reg.prog;
    assign flash_cmd = r_reg.cmd;
    assign flash_cmd_load = r_reg.cmd_load;
    assign flash_exec = r_reg.exec;
    assign page_byte = r_reg.pbyte;
    assign page_byte_high = r_reg.phigh;
    assign page_byte_write = r_reg.pwrite;
    assign page_word_inc = r_reg.winc;

    hold_reset_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_SH_DR && t_reg.ir == IR_HOLD_RESET && back_q[0])
        |=> core_hold_reset == $past(tdi))
        else $error("reset bit did not follow shifted data");
    tap_kept_a: assert property (@(posedge tck) disable iff (rst)
        (core_hold_reset && t_reg.st == TAP_IDLE && !tms) |=> t_reg.st == TAP_IDLE)
        else $error("reset bit disturbed the TAP state");
    unlock_match_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_UPD_DR && t_reg.ir == IR_UNLOCK && back_q[0])
        |=> t_reg.prog == ($past(t_reg.key) == UNLOCK_KEY))
        else $error("programming mode does not match key compare");
    capture_result_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_CAP_DR && t_reg.ir == IR_COMMAND)
        |=> t_reg.cmd == $past(t_reg.res))
        else $error("capture did not load previous result");
    cmd_shift_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_SH_DR && t_reg.ir == IR_COMMAND)
        |=> t_reg.cmd == {$past(tdi), $past(t_reg.cmd[CMD_W-1:1])})
        else $error("command register did not shift lsb first");
    exec_once_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_IDLE && t_reg.pend)
        |=> !t_reg.pend && t_reg.exec_tgl != $past(t_reg.exec_tgl))
        else $error("idle after update gave no execute event");
    page_alt_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_UPD_DR && t_reg.ir == IR_PAGE_LOAD && t_reg.prog)
        |=> t_reg.hi != $past(t_reg.hi))
        else $error("page byte half did not alternate");
    locked_gate_a: assert property (@(posedge tck) disable iff (rst)
        (t_reg.st == TAP_UPD_DR && !t_reg.prog)
        |=> $stable(t_reg.cmd_tgl) && $stable(t_reg.page_tgl))
        else $error("locked port issued a flash event");
    word_inc_a: assert property (@(posedge ref_clk) disable iff (rst)
        page_word_inc |=> page_byte_write && !page_byte_high)
        else $error("counter advance not followed by low byte write");
    page_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ev[2] && r_reg.prog) |-> ##[1:2] page_byte_write)
        else $error("page byte not written in time");
    disable_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!pin_q[0] ##1 !pin_q[0]) |=> !test_port_disable_bit)
        else $error("disable bit not cleared under external reset");
endmodule

// ==== test/jpp_prog_model.sv ====
module jpp_prog_model
(
    output logic      tck,  // Test clock, still outside frames
    output logic      tms,  // Test mode select
    output logic      tdi,  // Test data in
    input  wire logic tdo   // Test data out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam time HALF = 24ns;
    logic q;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Tdo read before the rising edge, it is settled since the last one
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #HALF;
        o = tdo;
        tck = 1'b1;
        #HALF;
        tck = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) step(1'b0, ~tdi, q);
    endtask
    // Long run in Test-Logic-Reset lets the synchronisers settle
    task automatic wake();
        repeat (10) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout);
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule

// ==== test/tb.sv ====
module tb
    import jpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, tck, tms, tdi, tdo, tdo_oe_n, fuse, ext_n, dset, dis_bit;
    logic hold, prog, ld, ex, fval, hi, wr, inc, inc_pend;
    logic [CMD_W-1:0]  fcmd, fres;
    logic [PAGE_W-1:0] pbyte;
    logic [15:0]       d;
    logic [9:0]        pg_log [$];
    int fails, tests_run, ld_cnt, ex_cnt, wr_cnt, oe_cnt, cyc, oe0;
    jpp_port i_dut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .test_port_enable_fuse(fuse),
        .ext_reset_n(ext_n), .disable_set(dset), .test_port_disable_bit(dis_bit),
        .core_hold_reset(hold), .prog_mode(prog), .flash_cmd(fcmd),
        .flash_cmd_load(ld), .flash_exec(ex), .flash_result(fres),
        .flash_result_valid(fval), .page_byte(pbyte), .page_byte_high(hi),
        .page_byte_write(wr), .page_word_inc(inc));
    jpp_prog_model i_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (ld === 1'b1) ld_cnt++;
        if (ex === 1'b1) ex_cnt++;
        if (inc === 1'b1) inc_pend = 1'b1;
        if (wr === 1'b1)
        begin
            wr_cnt++;
            pg_log.push_back({inc_pend, hi, pbyte});
            inc_pend = 1'b0;
        end
        if (cyc == 20000)
        begin
            fails++;
            finish_test();
        end
    end
    always @(posedge tck)
        if (tdo_oe_n === 1'b0) oe_cnt++;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (12) @(negedge ref_clk);
    endtask
    task automatic t_basic();
        check("tdo_oe_n", tdo_oe_n, 1);
        check("prog", prog, 0);
        check("dis_bit", dis_bit, 0);
        i_prog.scan(1'b1, IR_W, 16'h000F, d);
        check("ir_capture", d[3:0], 4'h1);
        $display("basic done");
    endtask
    task automatic t_hold();
        i_prog.scan(1'b1, IR_W, 16'h000C, d);
        i_prog.scan(1'b0, 1, 16'h0001, d);
        check("hold_on", hold, 1);
        i_prog.scan(1'b1, IR_W, 16'h000C, d);
        check("ir_while_hold", d[3:0], 4'h1);
        i_prog.scan(1'b0, 1, 16'h0000, d);
        check("hold_off", hold, 0);
        $display("hold done");
    endtask
    task automatic t_unlock();
        i_prog.scan(1'b1, IR_W, 16'h0005, d);
        i_prog.scan(1'b0, CMD_W, 16'h0123, d);
        settle();
        check("locked_cmd", ld_cnt, 0);
        i_prog.scan(1'b1, IR_W, 16'h0004, d);
        i_prog.scan(1'b0, KEY_W, 16'hA371, d);
        settle();
        check("bad_key", prog, 0);
        i_prog.scan(1'b0, KEY_W, 16'hA370, d);
        settle();
        check("good_key", prog, 1);
        $display("unlock done");
    endtask
    task automatic t_command();
        i_prog.scan(1'b1, IR_W, 16'h0005, d);
        i_prog.scan(1'b0, CMD_W, 16'h2A5B, d);
        settle();
        check("cmd_load", ld_cnt, 1);
        check("cmd_value", fcmd, 15'h2A5B);
        i_prog.idle(2);
        settle();
        check("exec", ex_cnt, 1);
        @(negedge ref_clk) fres = 15'h1234;
        fval = 1'b1;
        @(negedge ref_clk) fval = 1'b0;
        settle();
        // Result toggle needs test clock edges to cross before capture
        i_prog.idle(6);
        i_prog.scan(1'b0, CMD_W, 16'h0000, d);
        check("result", d, 16'h1234);
        $display("command done");
    endtask
    task automatic t_page();
        logic [9:0] exp [3];
        exp = '{10'h011, 10'h122, 10'h233};
        i_prog.scan(1'b1, IR_W, 16'h0006, d);
        for (int k = 0; k < 3; k++)
        begin
            i_prog.scan(1'b0, PAGE_W, {8'h00, exp[k][7:0]}, d);
            i_prog.idle(PAGE_LOAD_MAX_TCK);
            check("page_write", wr_cnt, k + 1);
            check("page_order", pg_log[k], exp[k]);
        end
        $display("page done");
    endtask
    task automatic t_access();
        @(negedge ref_clk) dset = 1'b1;
        @(negedge ref_clk) dset = 1'b0;
        settle();
        // Access level reaches the test domain only on test clock edges
        i_prog.idle(6);
        settle();
        check("dis_set", dis_bit, 1);
        check("prog_off", prog, 0);
        oe0 = oe_cnt;
        i_prog.wake();
        i_prog.scan(1'b1, IR_W, 16'h000F, d);
        check("no_drive", oe_cnt, oe0);
        @(negedge ref_clk) ext_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("dis_clear", dis_bit, 0);
        @(negedge ref_clk) ext_n = 1'b1;
        fuse = 1'b0;
        settle();
        i_prog.wake();
        i_prog.scan(1'b1, IR_W, 16'h000F, d);
        check("fuse_off", oe_cnt, oe0);
        @(negedge ref_clk) fuse = 1'b1;
        settle();
        i_prog.wake();
        i_prog.scan(1'b1, IR_W, 16'h0004, d);
        i_prog.scan(1'b0, KEY_W, KEY_RESET, d);
        $display("access done");
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        fuse = 1'b1;
        ext_n = 1'b1;
        dset = 1'b0;
        fval = 1'b0;
        fres = '0;
        inc_pend = 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        i_prog.wake();
        t_basic();
        t_hold();
        t_unlock();
        t_command();
        t_page();
        t_access();
        finish_test();
    end
endmodule
